//--- hw/mfio_device.sv
// Device end: wake and supply-enable control, reset pin, chip-select sensing and pin multiplexing.
// Assumes the radio core and the serial port cores sit on the user side.
`timescale 1ns/10ps
module mfio_device
    import mfio_pkg::*;
(
    // Clock, reset and enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Link to the pins.
    mfio_if.dev link,
    // Configuration port from the serial port cores.
    input wire logic cfg_wr,
    input wire logic [3:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    // Power and reset.
    input wire logic sleep_req,
    input wire logic deep_sleep_req,
    input wire logic soft_reset_req,
    output logic awake,
    output logic reset_seen,
    // Serial ports.
    input wire logic primary_data,
    input wire logic secondary_data,
    output logic txn_start,
    output logic secondary_selected,
    output logic secondary_serial_in,
    output logic secondary_serial_clock,
    // Radio.
    input wire logic tx_req,
    input wire logic rx_req,
    input wire logic frame_done,
    input wire logic aoa_sel,
    output logic tx_go,
    output logic rx_go,
    output logic abort_tx,
    output logic abort_rx,
    // Interrupt sources, grant, LEDs and general-purpose inputs.
    input wire logic irq_request,
    input wire logic grant_secondary,
    input wire logic [3:0] led_in,
    output logic sync_in,
    output pins_t gpio_in
);
    import mfio_pkg::*;

    localparam logic [10:0] TX_LEAD = 11'(`TX_LEAD_CYCLES);
    localparam logic [10:0] RX_LEAD = 11'(`RX_LEAD_CYCLES);

    dev_state_s s_reg;
    dev_state_s s_next;
    logic cs_fall;
    logic sec_unused;
    logic wake_evt;
    logic coex_in;
    logic coex_out;
    logic irq_primary;
    logic irq_secondary;
    logic ant_one;
    logic ant_two;
    pins_t po;
    pins_t poe;

    // Two-bit mode field of one pin.
    function automatic logic [1:0] mode_of(input logic [17:0] m, input int idx);
        mode_of = m[2*idx +: 2];
    endfunction

    // Direction and value of a pin used as general-purpose I/O.
    function automatic logic [1:0] gpio_drive(input dev_state_s st, input int idx);
        gpio_drive = {st.gpio_dir[8-idx], st.gpio_out[8-idx]};
    endfunction

    // Derived events and levels used by the pin multiplexer and the state update.
    always_comb begin
        cs_fall = s_reg.cs_prev & ~link.primary_port_select_low;
        sec_unused = mode_of(s_reg.mode, `PIN_SCLK) != 2'd0;
        wake_evt = ~link.primary_port_select_low | (sec_unused & link.secondary_port_select);
        coex_in = s_reg.coex_cfg[`COEX_SWAP_BIT] ? link.pin_level[`PIN_GPIO5] : link.pin_level[`PIN_GPIO4];
        case (s_reg.coex_cfg[`COEX_SEL_LSB +: 2])
            2'd0: coex_out = s_reg.rx_lead | s_reg.rx_on;
            2'd1: coex_out = s_reg.tx_lead | s_reg.tx_on;
            default: coex_out = s_reg.rx_lead | s_reg.rx_on | s_reg.tx_lead | s_reg.tx_on;
        endcase
        // Coexistence errors go to whichever host holds the grant; to the secondary host only while the dual-interrupt bit is set.
        irq_primary = irq_request | (s_reg.coex_err & ~grant_secondary);
        irq_secondary = s_reg.dual_en & (irq_request | (s_reg.coex_err & grant_secondary));
        // Combinational antenna change from aoa_sel keeps the switchover far inside the window.
        ant_one = s_reg.rx_on & ~aoa_sel;
        ant_two = s_reg.rx_on & aoa_sel;
    end

    // Pin multiplexer; an unused mode code leaves the pin as an input.
    always_comb begin
        po = '0;
        poe = '0;
        for (int i = 0; i < `PIN_COUNT; i++) begin
            case (mode_of(s_reg.mode, i))
                2'd0: begin
                    case (i)
                        `PIN_IRQ: {poe[i], po[i]} = {1'b1, irq_primary};
                        `PIN_SIRQ: {poe[i], po[i]} = {1'b1, irq_secondary};
                        `PIN_SMISO: {poe[i], po[i]} = {secondary_selected, secondary_data};
                        `PIN_SYNC, `PIN_SMOSI, `PIN_SCLK: {poe[i], po[i]} = 2'b00;
                        default: {poe[i], po[i]} = gpio_drive(s_reg, i);
                    endcase
                end
                2'd1: begin
                    case (i)
                        `PIN_GPIO6: {poe[i], po[i]} = {1'b1, s_reg.rx_on};
                        `PIN_GPIO5: {poe[i], po[i]} = {~s_reg.coex_cfg[`COEX_SWAP_BIT], coex_out};
                        `PIN_GPIO4: {poe[i], po[i]} = {s_reg.coex_cfg[`COEX_SWAP_BIT], coex_out};
                        `PIN_SMOSI, `PIN_SIRQ, `PIN_SMISO, `PIN_SCLK: {poe[i], po[i]} = {1'b1, led_in[8-i]};
                        default: {poe[i], po[i]} = gpio_drive(s_reg, i);
                    endcase
                end
                2'd2: begin
                    case (i)
                        `PIN_IRQ: {poe[i], po[i]} = {1'b1, s_reg.refclk};
                        `PIN_SYNC: {poe[i], po[i]} = {1'b1, ant_two};
                        `PIN_GPIO6: {poe[i], po[i]} = {1'b1, ant_one};
                        `PIN_GPIO5: {poe[i], po[i]} = {1'b1, s_reg.rx_lead | s_reg.rx_on};
                        `PIN_GPIO4: {poe[i], po[i]} = {1'b1, s_reg.tx_lead | s_reg.tx_on};
                        default: {poe[i], po[i]} = gpio_drive(s_reg, i);
                    endcase
                end
                default: {poe[i], po[i]} = 2'b00;
            endcase
        end
    end

    // Next-state logic for the whole device end.
    always_comb begin
        s_next = s_reg;
        s_next.txn_start = cs_fall;
        s_next.tx_go = 1'b0;
        s_next.rx_go = 1'b0;
        s_next.abort_tx = 1'b0;
        s_next.abort_rx = 1'b0;
        s_next.cs_prev = link.primary_port_select_low;
        s_next.refclk = ~s_reg.refclk;
        s_next.reset_seen = ~link.reset_pin_low;
        s_next.rst_drive = ~soft_reset_req;
        s_next.miso = ~link.primary_port_select_low & primary_data;
        s_next.rdata = (cfg_addr == `CFG_STATUS) ? {28'h0000000, s_reg.coex_err, s_reg.dual_en, 2'(s_reg.pwr)} :
                       (cfg_addr == `CFG_MODE) ? {14'h0000, s_reg.mode} : 32'h00000000;
        // Configuration writes; the dual-interrupt bit holds until written again.
        if (cfg_wr) begin
            case (cfg_addr)
                `CFG_MODE: s_next.mode = cfg_wdata[17:0];
                `CFG_GPIO_OUT: s_next.gpio_out = cfg_wdata[8:0];
                `CFG_GPIO_DIR: s_next.gpio_dir = cfg_wdata[8:0];
                `CFG_COEX: s_next.coex_cfg = cfg_wdata[4:0];
                `CFG_DUAL_INT: s_next.dual_en = cfg_wdata[0];
                `CFG_COEX_CLR: if (cfg_wdata[0]) s_next.coex_err = 1'b0;
                default: s_next.coex_err = s_reg.coex_err;
            endcase
        end
        // Power sequencing drives the supply enable.
        case (s_reg.pwr)
            PWR_DEEP, PWR_SLEEP: begin
                if (wake_evt) begin
                    s_next.pwr = PWR_WAKING;
                    s_next.wake_cnt = 16'h0000;
                end
            end
            PWR_WAKING: begin
                s_next.wake_cnt = s_reg.wake_cnt + 16'h0001;
                if (s_reg.wake_cnt == `WAKE_CYCLES - 16'h0001) s_next.pwr = PWR_ON;
            end
            PWR_ON: begin
                if (deep_sleep_req) s_next.pwr = PWR_DEEP;
                else if (sleep_req) s_next.pwr = PWR_SLEEP;
            end
            default: s_next.pwr = PWR_SLEEP;
        endcase
        // Transmit: switch leads the start by the lead time and holds through the frame.
        if (tx_req & ~s_reg.tx_lead & ~s_reg.tx_on) begin
            s_next.tx_lead = 1'b1;
            s_next.tx_cnt = 11'h000;
        end else if (s_reg.tx_lead) begin
            s_next.tx_cnt = s_reg.tx_cnt + 11'h001;
            if (s_reg.tx_cnt == TX_LEAD - 11'h001) begin
                s_next.tx_lead = 1'b0;
                s_next.tx_on = 1'b1;
                s_next.tx_go = 1'b1;
            end
        end else if (s_reg.tx_on & frame_done) begin
            s_next.tx_on = 1'b0;
        end
        // Receive: early switch leads by its own shorter time.
        if (rx_req & ~s_reg.rx_lead & ~s_reg.rx_on) begin
            s_next.rx_lead = 1'b1;
            s_next.rx_cnt = 11'h000;
        end else if (s_reg.rx_lead) begin
            s_next.rx_cnt = s_reg.rx_cnt + 11'h001;
            if (s_reg.rx_cnt == RX_LEAD - 11'h001) begin
                s_next.rx_lead = 1'b0;
                s_next.rx_on = 1'b1;
                s_next.rx_go = 1'b1;
            end
        end else if (s_reg.rx_on & frame_done) begin
            s_next.rx_on = 1'b0;
        end
        // Coexistence abort only when the input function is selected; set wins over clear.
        if (coex_in & mode_of(s_reg.mode, s_reg.coex_cfg[`COEX_SWAP_BIT] ? `PIN_GPIO5 : `PIN_GPIO4) == 2'd1) begin
            if (s_reg.coex_cfg[`COEX_ABORT_TX_BIT] & (s_reg.tx_lead | s_reg.tx_on)) begin
                s_next.tx_lead = 1'b0;
                s_next.tx_on = 1'b0;
                s_next.tx_go = 1'b0;
                s_next.abort_tx = 1'b1;
                s_next.coex_err = 1'b1;
            end
            if (s_reg.coex_cfg[`COEX_ABORT_RX_BIT] & (s_reg.rx_lead | s_reg.rx_on)) begin
                s_next.rx_lead = 1'b0;
                s_next.rx_on = 1'b0;
                s_next.rx_go = 1'b0;
                s_next.abort_rx = 1'b1;
                s_next.coex_err = 1'b1;
            end
        end
    end

    // State register; held while the clock enable is low.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{pwr: PWR_SLEEP, mode: `MODE_RESET, cs_prev: 1'b1, rst_drive: 1'b1, default: '0};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Outputs.
    assign link.external_supply_enable = (s_reg.pwr == PWR_WAKING) | (s_reg.pwr == PWR_ON);
    assign link.primary_serial_out = s_reg.miso;
    assign link.dev_reset_oe = 1'b1;
    assign link.dev_reset_out = s_reg.rst_drive;
    assign link.dev_pin_out = po;
    assign link.dev_pin_oe = poe;
    assign secondary_selected = link.secondary_port_select & ~sec_unused;
    assign secondary_serial_in = link.pin_level[`PIN_SMOSI];
    assign secondary_serial_clock = link.pin_level[`PIN_SCLK];
    assign sync_in = link.pin_level[`PIN_SYNC] & (mode_of(s_reg.mode, `PIN_SYNC) == 2'd0);
    assign gpio_in = {<<{link.pin_level}};
    assign cfg_rdata = s_reg.rdata;
    assign awake = s_reg.pwr == PWR_ON;
    assign reset_seen = s_reg.reset_seen;
    assign txn_start = s_reg.txn_start;
    assign tx_go = s_reg.tx_go;
    assign rx_go = s_reg.rx_go;
    assign abort_tx = s_reg.abort_tx;
    assign abort_rx = s_reg.abort_rx;
endmodule

//--- hw/mfio_host.sv
// Host end: an APB slave whose registers drive the chip selects, the reset pull and the pins.
// Assumes an APB master on the software side and the device end on the link.
`timescale 1ns/10ps
module mfio_host
    import mfio_pkg::*;
(
    // Clock, reset and enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link to the device.
    mfio_if.host link
);
    import mfio_pkg::*;

    host_state_s s_reg;
    host_state_s s_next;
    logic setup;
    logic access;

    // True when an offset is one of ours.
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `HOST_CTRL) | (a == `HOST_PIN_OUT) | (a == `HOST_PIN_OE) | (a == `HOST_STATUS);
    endfunction

    // Read data and the error answer are captured in the setup cycle so the access cycle completes at once.
    always_comb begin
        setup = psel & ~penable;
        access = psel & penable;
        s_next = s_reg;
        if (setup) begin
            s_next.pslverr = ~mapped(paddr);
            case (paddr)
                `HOST_CTRL: s_next.prdata = {29'h00000000, s_reg.ctrl};
                `HOST_PIN_OUT: s_next.prdata = {23'h000000, s_reg.pin_out};
                `HOST_PIN_OE: s_next.prdata = {23'h000000, s_reg.pin_oe};
                `HOST_STATUS: s_next.prdata = {20'h00000, link.pin_level, link.primary_serial_out,
                                              link.reset_pin_low, link.external_supply_enable};
                default: s_next.prdata = 32'h00000000;
            endcase
        end
        // Writes take effect at the access edge only.
        if (access & pwrite & mapped(paddr)) begin
            case (paddr)
                `HOST_CTRL: s_next.ctrl = pwdata[2:0];
                `HOST_PIN_OUT: s_next.pin_out = pwdata[8:0];
                `HOST_PIN_OE: s_next.pin_oe = pwdata[8:0];
                default: s_next.ctrl = s_reg.ctrl;
            endcase
        end
    end

    // State register; ctrl resets with primary select high, secondary select low and no pull.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{ctrl: 3'h1, default: '0};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Outputs; the reset pin is only ever pulled low, never driven high.
    assign pready = access;
    assign prdata = s_reg.prdata;
    assign pslverr = access & s_reg.pslverr;
    assign link.primary_port_select_low = s_reg.ctrl[0];
    assign link.secondary_port_select = s_reg.ctrl[1];
    assign link.host_reset_pull_oe = s_reg.ctrl[2];
    assign link.host_pin_out = s_reg.pin_out;
    assign link.host_pin_oe = s_reg.pin_oe;
endmodule

//--- shared/mfio_consts.svh
// Offsets, field positions, reset values and timing counts for the multi-function I/O link.
// Included by the package and by the testbench; holds definitions only.
`ifndef MFIO_CONSTS_SVH
`define MFIO_CONSTS_SVH
`define PIN_COUNT 9
`define CLK_PERIOD_NS 10
`define TX_LEAD_NS 10000
`define TX_LEAD_CYCLES ((`TX_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RX_LEAD_NS 100
`define RX_LEAD_CYCLES ((`RX_LEAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define AOA_SWITCH_NS 1000
`define AOA_SWITCH_CYCLES (`AOA_SWITCH_NS / `CLK_PERIOD_NS)
`define WAKE_CYCLES 16'h0010
// Device configuration port addresses.
`define CFG_MODE 4'h0
`define CFG_GPIO_OUT 4'h1
`define CFG_GPIO_DIR 4'h2
`define CFG_COEX 4'h3
`define CFG_DUAL_INT 4'h4
`define CFG_COEX_CLR 4'h5
`define CFG_STATUS 4'h6
`define COEX_SWAP_BIT 0
`define COEX_ABORT_TX_BIT 1
`define COEX_ABORT_RX_BIT 2
`define COEX_SEL_LSB 3
`define MODE_RESET 18'h00000
// Pin indices.
`define PIN_IRQ 0
`define PIN_SYNC 1
`define PIN_GPIO6 2
`define PIN_GPIO5 3
`define PIN_GPIO4 4
`define PIN_SMOSI 5
`define PIN_SIRQ 6
`define PIN_SMISO 7
`define PIN_SCLK 8
// Host APB register offsets.
`define HOST_CTRL 12'h000
`define HOST_PIN_OUT 12'h004
`define HOST_PIN_OE 12'h008
`define HOST_STATUS 12'h00c
`endif

//--- shared/mfio_if.sv
// Link between the transceiver's control and multi-function pins and the host side.
// Resolves every shared wire from the drivers' enables; the reset wire is pulled up.
`timescale 1ns/10ps
interface mfio_if;
    import mfio_pkg::*;
    logic external_supply_enable;
    logic secondary_port_select;
    logic primary_port_select_low;
    logic primary_serial_out;
    logic dev_reset_out;
    logic dev_reset_oe;
    logic host_reset_pull_oe;
    logic reset_pin_low;
    pins_t dev_pin_out;
    pins_t dev_pin_oe;
    pins_t host_pin_out;
    pins_t host_pin_oe;
    pins_t pin_level;

    // An open-drain pull from outside always wins, otherwise the device drive or the pull-up.
    assign reset_pin_low = host_reset_pull_oe ? 1'b0 : (dev_reset_oe ? dev_reset_out : 1'b1);
    // Device drive wins where both sides enable; undriven pins read low.
    assign pin_level = (dev_pin_oe & dev_pin_out) | (~dev_pin_oe & host_pin_oe & host_pin_out);

    modport dev(output external_supply_enable, primary_serial_out, dev_reset_out, dev_reset_oe,
                dev_pin_out, dev_pin_oe,
                input secondary_port_select, primary_port_select_low, reset_pin_low, pin_level);
    modport host(output secondary_port_select, primary_port_select_low, host_reset_pull_oe,
                 host_pin_out, host_pin_oe,
                 input external_supply_enable, primary_serial_out, reset_pin_low, pin_level);
endinterface

//--- shared/mfio_pkg.sv
// Types shared by the device end and the host end of the multi-function I/O link.
// Assumes the constants header sits beside it on the include path.
`include "mfio_consts.svh"
package mfio_pkg;
    typedef enum logic [1:0] {PWR_DEEP, PWR_SLEEP, PWR_WAKING, PWR_ON} power_e;
    typedef logic [`PIN_COUNT-1:0] pins_t;

    typedef struct packed {
        power_e pwr;
        logic [15:0] wake_cnt;
        logic cs_prev;
        logic [17:0] mode;
        pins_t gpio_out;
        pins_t gpio_dir;
        logic [4:0] coex_cfg;
        logic dual_en;
        logic coex_err;
        logic tx_lead;
        logic tx_on;
        logic rx_lead;
        logic rx_on;
        logic [10:0] tx_cnt;
        logic [10:0] rx_cnt;
        logic refclk;
        logic [31:0] rdata;
        logic txn_start;
        logic reset_seen;
        logic tx_go;
        logic rx_go;
        logic abort_tx;
        logic abort_rx;
        logic miso;
        logic rst_drive;
    } dev_state_s;

    typedef struct packed {
        logic [2:0] ctrl;
        pins_t pin_out;
        pins_t pin_oe;
        logic [31:0] prdata;
        logic pslverr;
    } host_state_s;
endpackage

//--- sim/mfio_checker.sv
// Concurrent checks on the pin link between the device end and the host end.
// Assumes one clock and an active-low asynchronous reset; sees only link signals.
`timescale 1ns/10ps
module mfio_checker
    import mfio_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Link signals.
    input wire logic external_supply_enable,
    input wire logic secondary_port_select,
    input wire logic primary_port_select_low,
    input wire logic primary_serial_out,
    input wire logic dev_reset_out,
    input wire logic dev_reset_oe,
    input wire logic host_reset_pull_oe,
    input wire logic reset_pin_low,
    input wire mfio_pkg::pins_t dev_pin_oe
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // The first edge after release still shows the reset levels of the pins.
    a_reset_levels: assert property ($rose(presetn) |-> !external_supply_enable && !primary_serial_out && dev_reset_out)
        else $error("pin levels after reset wrong");
    a_pins_default: assert property ($rose(presetn) |-> dev_pin_oe == 9'h041)
        else $error("pin directions after reset wrong");
    a_reset_drive: assert property (dev_reset_oe)
        else $error("reset pin not driven by device");
    a_pull_wins: assert property (host_reset_pull_oe |-> !reset_pin_low)
        else $error("outside pull did not reach reset wire");
    a_wake_primary: assert property (!external_supply_enable && !primary_port_select_low |=> external_supply_enable)
        else $error("primary select did not wake");
    a_no_wake: assert property (!external_supply_enable && primary_port_select_low && !secondary_port_select
        |=> !external_supply_enable)
        else $error("supply enable rose without wake");
    a_enable_hold: assert property ($rose(external_supply_enable) |-> external_supply_enable [*8])
        else $error("supply enable dropped during wake");
    a_serial_idle: assert property (primary_port_select_low |=> !primary_serial_out)
        else $error("serial out driven while deselected");
endmodule

//--- sim/tb_top.sv
// Testbench joining the device end and the host end through the link interface.
// Assumes the constants header on the include path; software side speaks APB.
`timescale 1ns/10ps
`include "mfio_consts.svh"
module tb_top;
    import mfio_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, cfg_wr, e, pready, pslverr;
    logic sleep_req, deep_sleep_req, soft_reset_req, primary_data, secondary_data, awake, reset_seen;
    logic tx_req, rx_req, frame_done, aoa_sel, irq_request, grant_secondary, txn_start, tx_go, rx_go;
    logic secondary_selected;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, cfg_wdata, cfg_rdata;
    logic [3:0] cfg_addr, led_in;
    int err_total, checked, cyc, txn_seen, n;
    mfio_if link ();
    mfio_host mfio_host_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    mfio_device mfio_device_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .link(link), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .sleep_req(sleep_req),
        .deep_sleep_req(deep_sleep_req), .soft_reset_req(soft_reset_req), .awake(awake),
        .reset_seen(reset_seen), .primary_data(primary_data), .secondary_data(secondary_data),
        .txn_start(txn_start), .secondary_selected(secondary_selected), .secondary_serial_in(),
        .secondary_serial_clock(), .tx_req(tx_req), .rx_req(rx_req), .frame_done(frame_done),
        .aoa_sel(aoa_sel), .tx_go(tx_go), .rx_go(rx_go), .abort_tx(), .abort_rx(),
        .irq_request(irq_request), .grant_secondary(grant_secondary), .led_in(led_in), .sync_in(),
        .gpio_in());
    mfio_checker mfio_checker_inst (.pclk(pclk), .presetn(presetn),
        .external_supply_enable(link.external_supply_enable), .secondary_port_select(link.secondary_port_select),
        .primary_port_select_low(link.primary_port_select_low), .primary_serial_out(link.primary_serial_out),
        .dev_reset_out(link.dev_reset_out), .dev_reset_oe(link.dev_reset_oe),
        .host_reset_pull_oe(link.host_reset_pull_oe), .reset_pin_low(link.reset_pin_low),
        .dev_pin_oe(link.dev_pin_oe));

    // Free-running clock.
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end

    // Counts transaction start pulses and cuts a hang short.
    always @(posedge pclk) begin
        txn_seen <= txn_seen + int'(txn_start === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    task end_of_test;
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task settle(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task cfg(input logic [3:0] a, input logic [31:0] d);
        @(posedge pclk);
        cfg_wr <= 1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge pclk);
        cfg_wr <= 0;
    endtask

    // Status after reset, and a refused unmapped offset.
    task t_reset;
        apb(0, `HOST_STATUS, 32'h0);
        chk(q === 32'h2 && e === 1'b0, "status after reset");
        apb(0, 12'h010, 32'h0);
        chk(e === 1'b1, "unmapped offset accepted");
    endtask

    // Wake by primary select, then light and deep sleep.
    task t_wake;
        for (int k = 0; k < 2; k++) begin
            apb(1, `HOST_CTRL, 32'h0);
            for (n = 0; n < 40 && awake !== 1'b1; n++) settle(1);
            chk(awake === 1'b1 && link.external_supply_enable === 1'b1, "no wake");
            primary_data <= 1;
            settle(2);
            chk(link.primary_serial_out === 1'b1, "serial out");
            chk(txn_seen == k + 1, "transaction start missing");
            apb(1, `HOST_CTRL, 32'h1);
            sleep_req <= (k == 0);
            deep_sleep_req <= (k == 1);
            cfg_addr <= `CFG_STATUS;
            settle(3);
            chk(link.external_supply_enable === 1'b0 && cfg_rdata[1:0] === 2'(1 - k), "sleep");
            sleep_req <= 0;
            deep_sleep_req <= 0;
        end
    endtask

    // Secondary select wakes while its port is unused, and selects once it is.
    task t_secondary;
        cfg(`CFG_MODE, 32'h10000);
        apb(1, `HOST_CTRL, 32'h3);
        for (n = 0; n < 40 && awake !== 1'b1; n++) settle(1);
        chk(awake === 1'b1 && secondary_selected === 1'b0, "secondary wake");
        apb(1, `HOST_CTRL, 32'h1);
        cfg(`CFG_MODE, 32'h0);
        apb(1, `HOST_CTRL, 32'h3);
        settle(1);
        chk(secondary_selected === 1'b1, "secondary select");
        apb(1, `HOST_CTRL, 32'h1);
    endtask

    // Interrupts go to the primary pin; the dual bit adds the secondary pin and stays.
    task t_irq;
        irq_request <= 1;
        settle(2);
        chk(link.pin_level[0] === 1'b1 && link.pin_level[6] === 1'b0, "primary irq");
        cfg(`CFG_DUAL_INT, 32'h1);
        settle(20);
        chk(link.pin_level[6] === 1'b1, "dual irq");
        irq_request <= 0;
    endtask

    // Switch lead times, antenna select, then GPIO drive.
    task t_radio;
        cfg(`CFG_MODE, 32'h2a8);
        tx_req <= 1;
        @(posedge pclk);
        tx_req <= 0;
        settle(2);
        chk(link.pin_level[4] === 1'b1 && tx_go !== 1'b1, "tx switch lead");
        for (n = 2; n < 1100 && tx_go !== 1'b1; n++) settle(1);
        chk(n >= `TX_LEAD_CYCLES - 2 && n <= `TX_LEAD_CYCLES + 1, "tx lead time");
        frame_done <= 1;
        @(posedge pclk);
        frame_done <= 0;
        settle(2);
        chk(link.pin_level[4] === 1'b0, "tx switch off");
        rx_req <= 1;
        @(posedge pclk);
        rx_req <= 0;
        settle(2);
        chk(link.pin_level[3] === 1'b1 && link.pin_level[2] === 1'b0, "rx lead");
        for (n = 2; n < 50 && rx_go !== 1'b1; n++) settle(1);
        chk(n >= `RX_LEAD_CYCLES - 2 && n <= `RX_LEAD_CYCLES + 1, "rx lead time");
        settle(1);
        chk(link.pin_level[2] === 1'b1 && link.pin_level[1] === 1'b0, "antenna one");
        aoa_sel <= 1;
        settle(1);
        chk(link.pin_level[2] === 1'b0 && link.pin_level[1] === 1'b1, "antenna two");
        frame_done <= 1;
        @(posedge pclk);
        frame_done <= 0;
        aoa_sel <= 0;
        cfg(`CFG_MODE, 32'h0);
        cfg(`CFG_GPIO_DIR, 32'h40);
        cfg(`CFG_GPIO_OUT, 32'h40);
        settle(1);
        chk(link.pin_level[2] === 1'b1, "gpio drive");
    endtask

    // Coexistence input on GPIO4 aborts a transmit and raises the error interrupt.
    task t_coex;
        cfg(`CFG_COEX, 32'h2);
        cfg(`CFG_MODE, 32'h100);
        tx_req <= 1;
        apb(1, `HOST_PIN_OE, 32'h10);
        tx_req <= 0;
        apb(1, `HOST_PIN_OUT, 32'h10);
        settle(2);
        chk(link.pin_level[0] === 1'b1 && tx_go !== 1'b1, "coex abort");
        apb(1, `HOST_PIN_OUT, 32'h0);
    endtask

    // Outside pull and the device's own reset drive.
    task t_reset_pin;
        apb(1, `HOST_CTRL, 32'h5);
        settle(2);
        chk(reset_seen === 1'b1 && link.reset_pin_low === 1'b0, "reset pull");
        apb(1, `HOST_CTRL, 32'h1);
        soft_reset_req <= 1;
        settle(2);
        chk(link.reset_pin_low === 1'b0, "soft reset drive");
        soft_reset_req <= 0;
        settle(2);
        chk(link.reset_pin_low === 1'b1, "reset pin released");
    endtask

    // Main sequence; the radio inputs stay idle unless a scenario pulses them.
    initial begin
        {presetn, psel, penable, pwrite, cfg_wr, sleep_req, deep_sleep_req, soft_reset_req} = 0;
        {primary_data, secondary_data, tx_req, rx_req, frame_done, aoa_sel, irq_request} = 0;
        {grant_secondary, paddr, pwdata, cfg_addr, cfg_wdata, led_in} = 0;
        {err_total, checked, cyc, txn_seen} = 0;
        ce = 1;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_wake();
        t_secondary();
        t_irq();
        t_radio();
        t_coex();
        t_reset_pin();
        end_of_test();
    end
endmodule
